// file: src/ata_cmd_pkg.sv
// Constants for the task-file command block: register map, bit
// positions, command codes, diagnostic codes and timing counts.
// Assumes a 200 MHz core clock and a 32-bit classic Wishbone bus.
package ata_cmd_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_FEATURE  = 8'h00;
    localparam logic [7:0] OFF_SECCOUNT = 8'h04;
    localparam logic [7:0] OFF_ADDR0    = 8'h08;
    localparam logic [7:0] OFF_ADDR1    = 8'h0C;
    localparam logic [7:0] OFF_ADDR2    = 8'h10;
    localparam logic [7:0] OFF_DEVSEL   = 8'h14;
    localparam logic [7:0] OFF_COMMAND  = 8'h18;
    localparam logic [7:0] OFF_ERROR    = 8'h1C;
    localparam logic [7:0] OFF_STATUS   = 8'h20;
    localparam logic [7:0] OFF_DATA     = 8'h24;
    localparam logic [7:0] OFF_CONFIG   = 8'h28;
    localparam logic [7:0] OFF_REVISION = 8'h2C;
    localparam logic [7:0] OFF_SECURITY = 8'h30;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int ST_BUSY  = 7;
    localparam int ST_READY = 6;
    localparam int ST_FAULT = 5;
    localparam int ST_DRQ   = 3;
    localparam int ST_ERR   = 0;
    localparam int ER_CRC   = 7;
    localparam int ER_ADDRESS_NOT_FOUND  = 4;
    localparam int ER_COMMAND_ABORTED  = 2;
    localparam int DS_LBA   = 6;
    localparam int DS_DEV   = 4;
    localparam int PW_MASTER_BIT = 0;
    localparam int PW_LEVEL_BIT  = 8;

    // ----------------------------------------------------------------
    // Command codes and result codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_DMA = 8'hCA;
    localparam logic [7:0] CMD_DIAG      = 8'h90;
    localparam logic [7:0] CMD_SET_PW    = 8'hF1;
    localparam logic [7:0] DIAG_PASS     = 8'h01;
    localparam logic [7:0] DIAG_FAIL     = 8'h02;
    // Signature values are arbitrary
    localparam logic [7:0] SIG_COUNT = 8'h01;
    localparam logic [7:0] SIG_ADDR0 = 8'h01;
    localparam logic [7:0] SIG_ADDR1 = 8'h00;
    localparam logic [7:0] SIG_ADDR2 = 8'h00;
    localparam logic [7:0] SIG_DEV   = 8'h00;

    // ----------------------------------------------------------------
    // Reset values and sizes
    // ----------------------------------------------------------------
    localparam logic [7:0]  STATUS_RESET  = 8'h40;
    localparam logic [15:0] REV_RESET     = 16'hFFFF;
    localparam logic [27:0] LAST_USER_LBA = 28'h0FFFFFF;
    localparam logic [8:0]  FULL_COUNT    = 9'd256;
    localparam logic [8:0]  PW_WORDS      = 9'd256;
    localparam logic [8:0]  PW_FIRST      = 9'd1;
    localparam logic [8:0]  PW_LAST       = 9'd16;
    localparam logic [8:0]  PW_REV_WORD   = 9'd17;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int DIAG_TIME_NS  = 1000;
    localparam int DIAG_CYCLES_I =
        (DIAG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [15:0] DIAG_CYCLES = DIAG_CYCLES_I[15:0];

    typedef enum logic [2:0] {
        ST_IDLE, ST_DMA, ST_DIAG, ST_PW
    } cmd_state_t;

endpackage

// file: src/ata_cmd_block.sv
// Task-file command interpreter: write DMA, device diagnostic and
// set password, reached over a classic Wishbone slave.
// Assumes the error and self-test pins are asynchronous to clock.
//
// What this block does
// - Command CAh starts a DMA write at the task-file address.
// - Sector count sets sectors transferred; 00h means 256.
// - Address bytes give bits 23:0, device select 3:0 gives 27:24.
// - Interface CRC error flagged only in Ultra DMA transfers.
// - Missing address flags address-not-found; out-of-range flags aborted.
// - Aborted flagged on Ultra DMA errors or incomplete actions.
// - Out-of-range address flags exactly one of aborted or not-found.
// - On DMA error the address registers hold the failing sector.
// - DMA error: busy, drq clear, ready set, fault, err as due.
// - Diagnostic 90h accepted whatever ready; select bit ignored.
// - Diagnostic runs the internal self-tests.
// - Diagnostic result in error register: 01h pass, else fail.
// - Diagnostic loads count, address and select with signature.
// - Diagnostic clears the device select bit.
// - Set password decoded from command code F1h.
// - Set password takes one 512-byte block from the host.
// - Word 0 bit 0 picks user/master, bit 8 level; words 1-16.
// - Revision code readable; 0000h or FFFFh means unsupported.
// - Set password: abort on failure, else clean ready status.
// - User password stored, lock armed for next power-on.
// - Master password stored, lock and level kept, revision taken.
`timescale 1ns/100ps
module ata_cmd_block
    import ata_cmd_pkg::*;
(
    input  wire logic        clock,             // Core clock
    input  wire logic        rst,               // Async reset, high
    input  wire logic        wb_cyc_i,          // Bus cycle
    input  wire logic        wb_stb_i,          // Bus strobe
    input  wire logic        wb_we_i,           // Bus write
    input  wire logic [7:0]  wb_adr_i,          // Byte address
    input  wire logic [3:0]  wb_sel_i,          // Byte lanes
    input  wire logic [31:0] wb_dat_i,          // Write data
    output logic      [31:0] wb_dat_o,          // Read data
    output logic             wb_ack_o,          // Bus acknowledge
    input  wire logic        crc_err_pin,       // Link CRC error
    input  wire logic        fault_pin,         // Device fault
    input  wire logic        addr_miss_pin,     // Sector not found
    input  wire logic        selftest_fail_pin, // Self-test failure
    output logic      [15:0] write_data,        // Data word to media
    output logic             write_valid,       // Data word strobe
    output logic      [27:0] write_lba,         // Sector of the word
    output logic             lock_armed         // Lock at next reset
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
        end else begin
            pin_meta_reg <= {selftest_fail_pin, addr_miss_pin,
                             fault_pin, crc_err_pin};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    logic crc_err;
    logic fault;
    logic addr_miss;
    logic selftest_fail;
    assign crc_err       = pin_sync_reg[0];
    assign fault         = pin_sync_reg[1];
    assign addr_miss     = pin_sync_reg[2];
    assign selftest_fail = pin_sync_reg[3];

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic ack_reg;
    logic wr_take;
    logic lane0;

    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            ack_reg <= 1'b0;
        else
            ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
    end

    // Writes act on the edge at which the master samples ack
    assign lane0   = wb_sel_i[0];
    assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & lane0;
    assign wb_ack_o = ack_reg;

    // ----------------------------------------------------------------
    // Task-file and state registers
    // ----------------------------------------------------------------
    cmd_state_t  state_reg;
    logic [7:0]  feature_input;
    logic [7:0]  sector_count_reg;
    logic [7:0]  address_byte0;
    logic [7:0]  address_byte1;
    logic [7:0]  address_byte2;
    logic [7:0]  device_select_reg;
    logic [7:0]  error_report_reg;
    logic [7:0]  status_flags_reg;
    logic        udma_mode_reg;
    logic [27:0] lba_reg;
    logic [16:0] words_left_reg;
    logic [15:0] diag_count_reg;
    logic [8:0]  pw_index_reg;
    logic        pw_master_reg;
    logic        pw_level_reg;
    logic [15:0] pw_buf_reg [16];
    logic [15:0] user_pw_reg [16];
    logic [15:0] master_pw_reg [16];
    logic [15:0] revision_reg;
    logic        level_max_reg;
    logic        user_set_reg;
    logic        master_set_reg;
    logic        lock_armed_reg;

    logic        wr_cmd;
    logic        wr_data;
    logic        ready;
    logic [27:0] start_lba;
    logic [8:0]  req_sectors;
    logic [28:0] end_lba;
    logic        out_of_range;
    logic        sector_end;

    assign ready   = status_flags_reg[ST_READY]
                   & ~status_flags_reg[ST_BUSY];
    assign wr_cmd  = wr_take & (wb_adr_i == OFF_COMMAND);
    assign wr_data = wr_take & (wb_adr_i == OFF_DATA)
                   & status_flags_reg[ST_DRQ];
    assign start_lba = {device_select_reg[3:0], address_byte2,
                        address_byte1, address_byte0};
    assign req_sectors = (sector_count_reg == 8'h00) ? FULL_COUNT
                       : {1'b0, sector_count_reg};
    assign end_lba = {1'b0, start_lba}
                   + {20'h00000, req_sectors};
    assign out_of_range = end_lba > ({1'b0, LAST_USER_LBA}
                                     + 29'h0000001);
    assign sector_end = words_left_reg[7:0] == 8'h01;

    // ----------------------------------------------------------------
    // Command sequencer and task-file updates
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg         <= ST_IDLE;
            feature_input     <= 8'h00;
            sector_count_reg  <= 8'h00;
            address_byte0     <= 8'h00;
            address_byte1     <= 8'h00;
            address_byte2     <= 8'h00;
            device_select_reg <= 8'h00;
            error_report_reg  <= 8'h00;
            status_flags_reg  <= STATUS_RESET;
            lba_reg           <= 28'h0000000;
            words_left_reg    <= 17'h00000;
            diag_count_reg    <= 16'h0000;
            pw_index_reg      <= 9'h000;
            pw_master_reg     <= 1'b0;
            pw_level_reg      <= 1'b0;
        end else begin
            unique case (state_reg)
            ST_IDLE: begin
                if (wr_take & ~status_flags_reg[ST_BUSY]) begin
                    unique case (wb_adr_i)
                    OFF_FEATURE:  feature_input <= wb_dat_i[7:0];
                    OFF_SECCOUNT: sector_count_reg <= wb_dat_i[7:0];
                    OFF_ADDR0:    address_byte0 <= wb_dat_i[7:0];
                    OFF_ADDR1:    address_byte1 <= wb_dat_i[7:0];
                    OFF_ADDR2:    address_byte2 <= wb_dat_i[7:0];
                    OFF_DEVSEL:   device_select_reg <= wb_dat_i[7:0];
                    default: ;
                    endcase
                end
                if (wr_cmd && wb_dat_i[7:0] == CMD_DIAG) begin
                    status_flags_reg <= 8'h80;
                    diag_count_reg   <= DIAG_CYCLES;
                    state_reg        <= ST_DIAG;
                end else if (wr_cmd && ready) begin
                    error_report_reg <= 8'h00;
                    if (wb_dat_i[7:0] == CMD_WRITE_DMA) begin
                        if (out_of_range) begin
                            // Aborted, so not-found stays clear
                            error_report_reg <= 8'h04;
                            status_flags_reg <= 8'h41;
                        end else begin
                            lba_reg <= start_lba;
                            words_left_reg <= {req_sectors,
                                               8'h00};
                            status_flags_reg <= 8'h48;
                            state_reg <= ST_DMA;
                        end
                    end else if (wb_dat_i[7:0] == CMD_SET_PW) begin
                        pw_index_reg     <= 9'h000;
                        status_flags_reg <= 8'h48;
                        state_reg        <= ST_PW;
                    end else begin
                        error_report_reg <= 8'h04;
                        status_flags_reg <= 8'h41;
                    end
                end
            end
            ST_DMA: begin
                if (wr_data) begin
                    words_left_reg <= words_left_reg - 17'h00001;
                    if (crc_err | fault | addr_miss) begin
                        error_report_reg[ER_CRC] <=
                            crc_err & udma_mode_reg;
                        error_report_reg[ER_ADDRESS_NOT_FOUND] <= addr_miss;
                        error_report_reg[ER_COMMAND_ABORTED] <=
                            crc_err | fault;
                        {device_select_reg[3:0], address_byte2,
                         address_byte1, address_byte0} <=
                            lba_reg;
                        status_flags_reg <= {2'b01, fault,
                                             5'b00001};
                        state_reg <= ST_IDLE;
                    end else if (words_left_reg == 17'h00001) begin
                        status_flags_reg <= 8'h40;
                        state_reg <= ST_IDLE;
                    end else if (sector_end) begin
                        lba_reg <= lba_reg + 28'h0000001;
                    end
                end
            end
            ST_DIAG: begin
                diag_count_reg <= diag_count_reg - 16'h0001;
                if (diag_count_reg == 16'h0001) begin
                    error_report_reg <= selftest_fail ? DIAG_FAIL
                                                      : DIAG_PASS;
                    sector_count_reg  <= SIG_COUNT;
                    address_byte0     <= SIG_ADDR0;
                    address_byte1     <= SIG_ADDR1;
                    address_byte2     <= SIG_ADDR2;
                    device_select_reg <= SIG_DEV & 8'hEF;
                    status_flags_reg  <= 8'h40;
                    state_reg         <= ST_IDLE;
                end
            end
            ST_PW: begin
                if (wr_data) begin
                    pw_index_reg <= pw_index_reg + 9'h001;
                    if (pw_index_reg == 9'h000) begin
                        pw_master_reg <= wb_dat_i[PW_MASTER_BIT];
                        pw_level_reg  <= wb_dat_i[PW_LEVEL_BIT];
                    end
                    if (pw_index_reg == PW_WORDS - 9'h001) begin
                        error_report_reg[ER_COMMAND_ABORTED] <= fault;
                        status_flags_reg <= {2'b01, fault, 4'b0000,
                                             fault};
                        state_reg <= ST_IDLE;
                    end
                end
            end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Password block capture and stored security state
    // ----------------------------------------------------------------
    logic pw_done;
    assign pw_done = (state_reg == ST_PW) & wr_data & ~fault
                   & (pw_index_reg == PW_WORDS - 9'h001);

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_pw
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    pw_buf_reg[gi]    <= 16'h0000;
                    user_pw_reg[gi]   <= 16'h0000;
                    master_pw_reg[gi] <= 16'h0000;
                end else begin
                    if (state_reg == ST_PW && wr_data &&
                        pw_index_reg == PW_FIRST + 9'(gi))
                        pw_buf_reg[gi] <= wb_dat_i[15:0];
                    if (pw_done && !pw_master_reg)
                        user_pw_reg[gi] <= pw_buf_reg[gi];
                    if (pw_done && pw_master_reg)
                        master_pw_reg[gi] <= pw_buf_reg[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            revision_reg   <= REV_RESET;
            level_max_reg  <= 1'b0;
            user_set_reg   <= 1'b0;
            master_set_reg <= 1'b0;
            lock_armed_reg <= 1'b0;
        end else if (pw_done) begin
            if (pw_master_reg) begin
                master_set_reg <= 1'b1;
            end else begin
                user_set_reg   <= 1'b1;
                level_max_reg  <= pw_level_reg;
                lock_armed_reg <= 1'b1;
            end
        end else if (state_reg == ST_PW && wr_data &&
                     pw_master_reg &&
                     pw_index_reg == PW_REV_WORD) begin
            revision_reg <= wb_dat_i[15:0];
        end
    end

    // ----------------------------------------------------------------
    // Configuration register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            udma_mode_reg <= 1'b0;
        else if (wr_take && wb_adr_i == OFF_CONFIG)
            udma_mode_reg <= wb_dat_i[0];
    end

    // ----------------------------------------------------------------
    // Read data, registered while ack rises
    // ----------------------------------------------------------------
    logic [31:0] rd_data_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data_reg <= 32'h00000000;
        end else if (wb_cyc_i & wb_stb_i & ~ack_reg) begin
            unique case (wb_adr_i)
            OFF_SECCOUNT: rd_data_reg <= {24'h0, sector_count_reg};
            OFF_ADDR0:    rd_data_reg <= {24'h0, address_byte0};
            OFF_ADDR1:    rd_data_reg <= {24'h0, address_byte1};
            OFF_ADDR2:    rd_data_reg <= {24'h0, address_byte2};
            OFF_DEVSEL:   rd_data_reg <= {24'h0, device_select_reg};
            OFF_ERROR:    rd_data_reg <= {24'h0, error_report_reg};
            OFF_STATUS:   rd_data_reg <= {24'h0, status_flags_reg};
            OFF_CONFIG:   rd_data_reg <= {31'h0, udma_mode_reg};
            OFF_REVISION: rd_data_reg <= {16'h0, revision_reg};
            OFF_SECURITY: rd_data_reg <= {28'h0, lock_armed_reg,
                                          level_max_reg,
                                          master_set_reg,
                                          user_set_reg};
            default:      rd_data_reg <= 32'h00000000;
            endcase
        end
    end

    assign wb_dat_o = rd_data_reg;

    // ----------------------------------------------------------------
    // Media-side data stream
    // ----------------------------------------------------------------
    logic [15:0] wdata_reg;
    logic        wvalid_reg;
    logic [27:0] wlba_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wdata_reg  <= 16'h0000;
            wvalid_reg <= 1'b0;
            wlba_reg   <= 28'h0000000;
        end else begin
            wvalid_reg <= (state_reg == ST_DMA) & wr_data
                        & ~(crc_err | fault | addr_miss);
            if ((state_reg == ST_DMA) & wr_data) begin
                wdata_reg <= wb_dat_i[15:0];
                wlba_reg  <= lba_reg;
            end
        end
    end

    assign write_data  = wdata_reg;
    assign write_valid = wvalid_reg;
    assign write_lba   = wlba_reg;
    assign lock_armed  = lock_armed_reg;

endmodule // ata_cmd_block

// file: tb/ata_cmd_block_monitor.sv
// Assertions on the command block's bus and media ports.
// Bound into every ata_cmd_block; one clock domain, async reset.
`timescale 1ns/100ps
module ata_cmd_block_monitor import ata_cmd_pkg::*; (
    input wire logic        clock,       // Core clock
    input wire logic        rst,         // Reset
    input wire logic        wb_cyc_i,    // Cycle
    input wire logic        wb_stb_i,    // Strobe
    input wire logic        wb_we_i,     // Write
    input wire logic [7:0]  wb_adr_i,    // Address
    input wire logic [31:0] wb_dat_i,    // Write data
    input wire logic [31:0] wb_dat_o,    // Read data
    input wire logic        wb_ack_o,    // Acknowledge
    input wire logic [15:0] write_data,  // Media word
    input wire logic        write_valid, // Media strobe
    input wire logic        lock_armed   // Lock state
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack not one cycle after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_WV_CAUSE: assert property (write_valid |->
        $past(wb_ack_o) && $past(wb_we_i) && $past(wb_adr_i) == OFF_DATA)
        else $error("media word without data write");
    AST_WV_DATA: assert property (write_valid |->
        write_data == 16'($past(wb_dat_i)))
        else $error("media word differs from bus data");
    AST_WV_PULSE: assert property (write_valid |=> !write_valid)
        else $error("media strobe too long");
    AST_LOCK_KEEP: assert property (lock_armed |=> lock_armed)
        else $error("lock dropped without reset");
    AST_RDY_IDLE: assert property (wb_ack_o && !wb_we_i &&
        wb_adr_i == OFF_STATUS && !wb_dat_o[ST_BUSY] |-> wb_dat_o[ST_READY])
        else $error("not busy but not ready");
    AST_DRQ_FREE: assert property (wb_ack_o && !wb_we_i &&
        wb_adr_i == OFF_STATUS |-> !(wb_dat_o[ST_BUSY] && wb_dat_o[ST_DRQ]))
        else $error("busy and data request together");
    cover property (write_valid);
    cover property ($rose(lock_armed));
    cover property (wb_ack_o && wb_adr_i == OFF_STATUS && wb_dat_o[ST_ERR]);
endmodule // ata_cmd_block_monitor
bind ata_cmd_block ata_cmd_block_monitor ata_cmd_block_monitor_inst (
    .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .write_data(write_data),
    .write_valid(write_valid), .lock_armed(lock_armed));

// file: tb/media_sink.sv
// Media-side model: counts written words, keeps the last sector.
// Assumes one word per write_valid pulse.
`timescale 1ns/100ps
module media_sink (
    input wire logic        clock,       // Core clock
    input wire logic        rst,         // Reset
    input wire logic        write_valid, // Word strobe
    input wire logic [27:0] write_lba,   // Word sector
    output int              n_words,     // Words taken
    output logic     [27:0] last_lba     // Last sector seen
);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            n_words  <= 0;
            last_lba <= 28'h0;
        end else if (write_valid) begin
            n_words  <= n_words + 1;
            last_lba <= write_lba;
        end
    end
endmodule // media_sink

// file: tb/ata_cmd_block_tb.sv
// Self-checking bench for the command block, hand-driven Wishbone.
// Assumes one-cycle ack and the register map of ata_cmd_pkg.
`timescale 1ns/100ps
module ata_cmd_block_tb import ata_cmd_pkg::*; ;
    logic        clock = 0, rst = 1, cyc = 0, stb = 0, we = 0;
    logic        crc = 0, miss = 0, stf = 0, flt = 0, ack, wv, lock;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, dat_o, q;
    logic [15:0] wd;
    logic [27:0] wl, last_lba;
    int          err_total = 0, n_tests = 0, n_words;
    initial forever #2.5 clock = ~clock;
    ata_cmd_block ata_cmd_block_inst (.clock(clock), .rst(rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .crc_err_pin(crc), .fault_pin(flt), .addr_miss_pin(miss),
        .selftest_fail_pin(stf), .write_data(wd), .write_valid(wv),
        .write_lba(wl), .lock_armed(lock));
    media_sink media_sink_inst (.clock(clock), .rst(rst),
        .write_valid(wv), .write_lba(wl), .n_words(n_words),
        .last_lba(last_lba));
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clock);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do @(posedge clock); while (ack !== 1'b1);
        q = dat_o;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        cmp($sformatf("reg %h", a), e, q);
    endtask
    task automatic setup(input logic [7:0] c, input logic [27:0] l);
        wb(1'b1, OFF_SECCOUNT, {24'h0, c});
        wb(1'b1, OFF_ADDR0, {24'h0, l[7:0]});
        wb(1'b1, OFF_ADDR1, {24'h0, l[15:8]});
        wb(1'b1, OFF_ADDR2, {24'h0, l[23:16]});
        wb(1'b1, OFF_DEVSEL, {24'h0, 4'h5, l[27:24]});
    endtask
    task automatic t_regs;
        rchk(OFF_STATUS, 32'h40);
        rchk(8'h3C, 32'h0);
        wb(1'b1, OFF_SECCOUNT, 32'hA5);
        rchk(OFF_SECCOUNT, 32'hA5);
        rchk(OFF_REVISION, 32'hFFFF);
    endtask
    task automatic t_dma;
        setup(8'h02, 28'h0123456);
        wb(1'b1, OFF_COMMAND, {24'h0, CMD_WRITE_DMA});
        rchk(OFF_STATUS, 32'h48);
        for (int k = 0; k < 513; k++) wb(1'b1, OFF_DATA, 32'(k));
        cmp("words", 32'd512, n_words);
        cmp("lba", 32'h0123457, {4'h0, last_lba});
        rchk(OFF_STATUS, 32'h40);
        rchk(OFF_ERROR, 32'h0);
        rchk(OFF_DEVSEL, 32'h50);
    endtask
    task automatic t_range;
        for (int i = 0; i < 2; i++) begin
            setup(i ? 8'h01 : 8'h00, i ? 28'h1000000 : 28'h0FFFF01);
            wb(1'b1, OFF_COMMAND, {24'h0, CMD_WRITE_DMA});
            rchk(OFF_ERROR, 32'h04);
            rchk(OFF_STATUS, 32'h41);
        end
    endtask
    task automatic t_err;
        wb(1'b1, OFF_CONFIG, 32'h1);
        for (int i = 0; i < 3; i++) begin
            setup(8'h02, 28'h0000010);
            wb(1'b1, OFF_COMMAND, {24'h0, CMD_WRITE_DMA});
            {flt, crc, miss} <= 3'b001 << i;
            repeat (4) @(posedge clock);
            wb(1'b1, OFF_DATA, 32'h0);
            {flt, crc, miss} <= 3'b000;
            rchk(OFF_ERROR, i == 2 ? 32'h04 : i ? 32'h84 : 32'h10);
            rchk(OFF_STATUS, i == 2 ? 32'h61 : 32'h41);
            rchk(OFF_ADDR0, 32'h10);
        end
    endtask
    task automatic t_diag;
        logic [7:0] sig [5] = '{SIG_COUNT, SIG_ADDR0, SIG_ADDR1,
                                SIG_ADDR2, SIG_DEV};
        for (int i = 0; i < 2; i++) begin
            stf <= i[0];
            wb(1'b1, OFF_DEVSEL, 32'h10);
            wb(1'b1, OFF_COMMAND, {24'h0, CMD_DIAG});
            rchk(OFF_STATUS, 32'h80);
            while (q[ST_BUSY] !== 1'b0)
                wb(1'b0, OFF_STATUS, 32'h0);
            rchk(OFF_ERROR, i ? DIAG_FAIL : DIAG_PASS);
            for (int k = 0; k < 5; k++)
                rchk(OFF_SECCOUNT + 8'(4 * k), sig[k]);
        end
        stf <= 1'b0;
    endtask
    task automatic t_pw;
        logic [15:0] w;
        for (int i = 0; i < 2; i++) begin
            wb(1'b1, OFF_COMMAND, {24'h0, CMD_SET_PW});
            rchk(OFF_STATUS, 32'h48);
            for (int k = 0; k < 256; k++) begin
                w = (k == 17) ? 16'h1234 : (k == 0) ? 16'(i * 16'hFFFF)
                                                    : 16'(k);
                wb(1'b1, OFF_DATA, {16'h0, w});
            end
            rchk(OFF_STATUS, 32'h40);
            rchk(OFF_SECURITY, i ? 32'h0B : 32'h09);
            rchk(OFF_REVISION, i ? 32'h1234 : 32'hFFFF);
            cmp("lock", 32'h1, {31'h0, lock});
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_dma();
        t_range();
        t_err();
        t_diag();
        t_pw();
        report_and_stop();
    end
    initial begin
        repeat (60000) @(posedge clock);
        err_total++;
        report_and_stop();
    end
endmodule // ata_cmd_block_tb
